// ===== include/gpio_cfg_pkg.sv
// Purpose: Shared types and constants for the configurable port line block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Mode codes follow the 3-bit per-line configuration layout
package gpio_cfg_pkg;

  // ----------------------------------------------------------------
  // Line configuration modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    MODE_IN_FLOAT,
    MODE_IN_PULLUP,
    MODE_OUT_PP,
    MODE_OUT_OD,
    MODE_BIDIR_PP,
    MODE_BIDIR_OD,
    MODE_AF_PP,
    MODE_ALT_FUNC_OPEN_DRAIN_MODE
  } line_mode_t;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam int         LINES_DEF      = 8;
  localparam int         ALT_SEL_W      = 2;
  localparam line_mode_t MODE_RST       = MODE_IN_FLOAT;
  localparam logic       OUT_VAL_RST    = 1'b0;

  // Per-line configuration written by software
  typedef struct packed
  {
    line_mode_t           mode;
    logic                 out_val;
    logic [ALT_SEL_W-1:0] alt_sel;
    logic                 analog_sel;
  } line_cfg_t;

  // What the line drives onto the pin
  typedef struct packed
  {
    logic drive_val;
    logic drive_en;
    logic pullup_en;
  } pad_ctl_t;

endpackage : gpio_cfg_pkg

// ===== rtl/io_port_bit_config.sv
// Purpose: Per-line configuration of a general-purpose port
// Assumes: Pin levels arrive asynchronously and are synchronised here
// Notes:   Pad resolution (pull-up, open drain wire) is outside
//          Pad controls are combinational so a peripheral drives its own pin at once
//          Lines outside the pull-up mask simply ignore the pull-up mode
//
// How it works
// - Every line has its own mode: input, output, bidirectional or alternate.
// - Output lines choose push-pull or open-drain per bit by mode.
// - Pull-up on a capable line follows the input-pullup mode.
// - Lines without pull-up hardware never assert their pull-up enable.
// - Configuration clears asynchronously as soon as reset goes low.
// - During reset each line is a floating input, driver off, no pull-up.
// - Only one alternate output may own a pin at once.
// - Digital alternate inputs see the pin unless cut for analog; analog needs explicit selection.
// - Analog-selected pin in alternate open-drain mode cuts the digital input.
// - Alternate output driving the pin also loops back to the alternate input of that pin.
`timescale 1ns/1ns

module io_port_bit_config
#(
  parameter int                  LINES      = gpio_cfg_pkg::LINES_DEF,
  parameter logic [LINES-1:0]    PULLUP_HAS = '1
)
(
  // Clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_b_i,
  // Configuration write port
  input  wire logic                                 cfg_we_i,
  input  wire logic [$clog2(LINES)-1:0]             cfg_line_i,
  input  wire gpio_cfg_pkg::line_cfg_t              cfg_data_i,
  // Configuration and state readback
  output logic [LINES-1:0][2:0]                     mode_o,
  output logic [LINES-1:0]                          pin_level_o,
  // Alternate function outputs, one set per selectable source
  input  wire logic [LINES-1:0][(1<<gpio_cfg_pkg::ALT_SEL_W)-1:0] alt_out_i,
  output logic [LINES-1:0]                          alt_in_o,
  output logic [LINES-1:0]                          alt_in_analog_o,
  // Pins
  input  wire logic [LINES-1:0]                     pin_i,
  output logic [LINES-1:0]                          pin_o,
  output logic [LINES-1:0]                          pin_oe_o,
  output logic [LINES-1:0]                          pullup_en_o
);

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  // Unpacked so each line keeps its own struct
  gpio_cfg_pkg::line_cfg_t cfg_r [LINES];
  logic [LINES-1:0]        pin_meta_r;
  logic [LINES-1:0]        pin_sync_r;

  // Independent per-line registers, cleared at once by reset
  // Limitation: with LINES not a power of two, high indices must not be written
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < LINES; i++)
      begin
        cfg_r[i].mode       <= gpio_cfg_pkg::MODE_RST;
        cfg_r[i].out_val    <= gpio_cfg_pkg::OUT_VAL_RST;
        cfg_r[i].alt_sel    <= '0;
        cfg_r[i].analog_sel <= 1'b0;
      end
    end
    else if (cfg_we_i)
    begin
      cfg_r[cfg_line_i] <= cfg_data_i;
    end
  end

  // Two-flop pin synchroniser; only the second stage is read
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Per-line pad control
  // ----------------------------------------------------------------
  // Single alt_sel index picks exactly one source, so two owners are impossible
  logic [LINES-1:0] drv_val;
  logic [LINES-1:0] is_od;
  logic [LINES-1:0] is_out;
  logic [LINES-1:0] is_af;

  always_comb
  begin
    for (int i = 0; i < LINES; i++)
    begin
      gpio_cfg_pkg::line_mode_t m;
      m         = cfg_r[i].mode;
      mode_o[i] = m;
      is_af[i]  = (m == gpio_cfg_pkg::MODE_AF_PP) || (m == gpio_cfg_pkg::MODE_ALT_FUNC_OPEN_DRAIN_MODE);
      is_od[i]  = (m == gpio_cfg_pkg::MODE_OUT_OD) || (m == gpio_cfg_pkg::MODE_BIDIR_OD)
                || (m == gpio_cfg_pkg::MODE_ALT_FUNC_OPEN_DRAIN_MODE);
      is_out[i] = !((m == gpio_cfg_pkg::MODE_IN_FLOAT) || (m == gpio_cfg_pkg::MODE_IN_PULLUP));
      // One alternate source per pin, picked by index
      drv_val[i] = is_af[i] ? alt_out_i[i][cfg_r[i].alt_sel]
                            : cfg_r[i].out_val;
      // Open drain only sinks; high releases the pin
      pin_o[i]    = is_od[i] ? 1'b0 : drv_val[i];
      pin_oe_o[i] = is_out[i] && !(is_od[i] && drv_val[i]);
      // Pull-up only where the pad really has one
      pullup_en_o[i] = PULLUP_HAS[i]
                       && (m == gpio_cfg_pkg::MODE_IN_PULLUP);
    end
  end

  // ----------------------------------------------------------------
  // Input paths toward peripherals
  // ----------------------------------------------------------------
  // Digital alternate input is wired unless cut for analog; loopback when driving as AF
  always_comb
  begin
    for (int i = 0; i < LINES; i++)
    begin
      if (cfg_r[i].analog_sel && (cfg_r[i].mode == gpio_cfg_pkg::MODE_ALT_FUNC_OPEN_DRAIN_MODE))
      begin
        pin_level_o[i] = 1'b0;
        alt_in_o[i]    = 1'b0;
      end
      else if (is_af[i] && pin_oe_o[i])
      begin
        pin_level_o[i] = pin_sync_r[i];
        alt_in_o[i]    = drv_val[i];
      end
      else
      begin
        pin_level_o[i] = pin_sync_r[i];
        alt_in_o[i]    = pin_sync_r[i];
      end
      // Analog path needs explicit software selection
      alt_in_analog_o[i] = cfg_r[i].analog_sel;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // One checker set per line; every line is checked on its own
  genvar g;
  for (g = 0; g < LINES; g++)
  begin : g_chk
    a_od_no_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (is_od[g] && pin_oe_o[g]) |-> (pin_o[g] == 1'b0))
      else $error("open drain drove high");
    a_od_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (is_od[g] && drv_val[g]) |-> !pin_oe_o[g])
      else $error("open drain did not release");
    a_pullup_absent: assert property (@(posedge clk_i)
      !PULLUP_HAS[g] |-> !pullup_en_o[g])
      else $error("pull-up on line without one");
    a_reset_float: assert property (@(posedge clk_i)
      $rose(rst_b_i) |-> (!pin_oe_o[g] && !pullup_en_o[g]))
      else $error("line not floating after reset");
    a_pullup_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (PULLUP_HAS[g] && mode_o[g] == 3'(gpio_cfg_pkg::MODE_IN_PULLUP)) |-> pullup_en_o[g])
      else $error("pull-up not enabled");
    a_analog_cut: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cfg_r[g].analog_sel && mode_o[g] == 3'(gpio_cfg_pkg::MODE_ALT_FUNC_OPEN_DRAIN_MODE)) |-> !alt_in_o[g])
      else $error("digital input not cut");
    a_af_loop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (is_af[g] && pin_oe_o[g] && !cfg_r[g].analog_sel) |-> (alt_in_o[g] == drv_val[g]))
      else $error("alternate loopback missing");
    a_in_path: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !is_af[g] |-> (alt_in_o[g] == pin_sync_r[g]))
      else $error("alternate input not tied to pin");
    a_pp_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (is_out[g] && !is_od[g]) |-> (pin_oe_o[g] && pin_o[g] == drv_val[g]))
      else $error("push-pull not driving");
    // A write lands whole in the addressed line only
    a_cfg_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cfg_we_i && cfg_line_i == g) |=> (cfg_r[g] == $past(cfg_data_i)))
      else $error("configuration not stored");
    // Reset acts before the next edge; a synchronous clear would show the old mode here
    a_async_clear: assert property (@(posedge clk_i)
      $fell(rst_b_i) |-> (mode_o[g] == 3'(gpio_cfg_pkg::MODE_RST)))
      else $error("configuration survived reset");
    // Floating input for as long as reset is held
    a_reset_hold: assert property (@(posedge clk_i)
      !rst_b_i |-> (!pin_oe_o[g] && !pullup_en_o[g] && !alt_in_o[g]))
      else $error("line active during reset");
    // Input modes never reach the pin driver
    a_in_no_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ((mode_o[g] == 3'(gpio_cfg_pkg::MODE_IN_FLOAT))
       || (mode_o[g] == 3'(gpio_cfg_pkg::MODE_IN_PULLUP))) |-> !pin_oe_o[g])
      else $error("input line drives pin");
    // Pull-up switches off again as soon as another mode is chosen
    a_pullup_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (mode_o[g] != 3'(gpio_cfg_pkg::MODE_IN_PULLUP)) |-> !pullup_en_o[g])
      else $error("pull-up left on");
    // Level lags the pin by the two synchroniser stages once both left reset
    a_level_sync: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ($past(rst_b_i) && $past(rst_b_i, 2)
       && !(cfg_r[g].analog_sel && mode_o[g] == 3'(gpio_cfg_pkg::MODE_ALT_FUNC_OPEN_DRAIN_MODE)))
       |-> (pin_level_o[g] == $past(pin_i[g], 2)))
      else $error("pin level not synchronised");
    // Cut analog pins report a steady low level
    a_analog_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cfg_r[g].analog_sel && mode_o[g] == 3'(gpio_cfg_pkg::MODE_ALT_FUNC_OPEN_DRAIN_MODE)) |-> !pin_level_o[g])
      else $error("analog pin level not held low");
    // Main scenarios
    c_alt_func_open_drain_mode: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      is_af[g] && is_od[g] && !pin_oe_o[g]);
    c_pullup: cover property (@(posedge clk_i) disable iff (!rst_b_i) pullup_en_o[g]);
    c_analog: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      alt_in_analog_o[g] && mode_o[g] == 3'(gpio_cfg_pkg::MODE_ALT_FUNC_OPEN_DRAIN_MODE));
    c_af_loop: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      is_af[g] && pin_oe_o[g] && (alt_in_o[g] != pin_sync_r[g]));
  end

endmodule : io_port_bit_config

// ===== testbench/pin_board_model.sv
// Purpose: Board side of the port pins
// Assumes: Design drive wins over board drive
// Notes:   Floating pins toggle so no stale level is seen
`timescale 1ns/1ns

module pin_board_model
(
  // Clock
  input  wire logic       clk_i,
  // Design pad controls
  input  wire logic [7:0] drive_i,
  input  wire logic [7:0] drive_en_i,
  input  wire logic [7:0] pullup_i,
  // Board drivers
  input  wire logic [7:0] board_en_i,
  input  wire logic [7:0] board_val_i,
  // Resolved pin level
  output logic      [7:0] level_o
);
  logic [7:0] float_r = 8'h55;

  // Undriven pin wanders every cycle
  always_ff @(posedge clk_i)
    float_r <= ~float_r;

  // Open drain releases to board or pull-up
  always_comb
    for (int n = 0; n < 8; n++)
      level_o[n] = drive_en_i[n] ? drive_i[n] : board_en_i[n] ? board_val_i[n] :
                   pullup_i[n] ? 1'b1 : float_r[n];
endmodule : pin_board_model

// ===== testbench/test_io_port_bit_config.sv
// Purpose: Self-checking bench for the port line block
// Assumes: Eight lines, upper four without pull-up hardware
// Notes:   Unknown pin levels are masked from comparison
`timescale 1ns/1ns

module test_io_port_bit_config;
  localparam logic [7:0] PU_HAS = 8'h0F;
  logic clk_i = 1'b0, rst_b_i = 1'b1, cfg_we_i = 1'b0;
  logic [2:0] cfg_line_i = 3'h0;
  gpio_cfg_pkg::line_cfg_t cfg_data_i = '0;
  gpio_cfg_pkg::line_cfg_t cfg_m [8] = '{default: '0};
  logic [7:0][3:0] alt_out_i = '0;
  logic [7:0][2:0] mode_o;
  logic [7:0] brd_en = 8'h00, brd_val = 8'h00, pin_i, pin_o, pin_oe_o, pullup_en_o;
  logic [7:0] pin_level_o, alt_in_o, alt_in_analog_o;
  int n_errors = 0, tests_run = 0;

  io_port_bit_config #(.LINES(8), .PULLUP_HAS(PU_HAS)) dut_u (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .cfg_we_i(cfg_we_i), .cfg_line_i(cfg_line_i), .cfg_data_i(cfg_data_i),
    .mode_o(mode_o), .pin_level_o(pin_level_o), .alt_out_i(alt_out_i), .alt_in_o(alt_in_o),
    .alt_in_analog_o(alt_in_analog_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pullup_en_o(pullup_en_o));
  pin_board_model board_u (.clk_i(clk_i), .drive_i(pin_o), .drive_en_i(pin_oe_o),
    .pullup_i(pullup_en_o), .board_en_i(brd_en), .board_val_i(brd_val), .level_o(pin_i));

  initial forever #10 clk_i = ~clk_i;

  task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task summarize;
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task wr(input int ln, input logic [6:0] d);
    @(negedge clk_i);
    cfg_we_i = 1'b1;
    cfg_line_i = ln[2:0];
    cfg_data_i = d;
    cfg_m[ln] = d;
    @(negedge clk_i);
    cfg_we_i = 1'b0;
  endtask : wr

  // Reference model of every line, compared as whole vectors
  task check_all;
    logic [7:0][2:0] e_md;
    logic [7:0] e_oe, e_src, e_pu, e_lv, k_lv, e_ai, k_ai, e_an;
    logic [2:0] m;
    for (int n = 0; n < 8; n++)
    begin
      m = cfg_m[n].mode;
      e_md[n] = m;
      e_an[n] = cfg_m[n].analog_sel;
      e_src[n] = m >= 3'h6 ? alt_out_i[n][cfg_m[n].alt_sel] : cfg_m[n].out_val;
      e_oe[n] = m >= 3'h2 && !(m[0] && e_src[n]);
      e_pu[n] = m == 3'h1 && PU_HAS[n];
      e_lv[n] = e_oe[n] ? e_src[n] : brd_en[n] ? brd_val[n] : 1'b1;
      k_lv[n] = e_oe[n] || brd_en[n] || e_pu[n];
      e_ai[n] = e_lv[n];
      k_ai[n] = k_lv[n];
      if (e_an[n] && m == 3'h7) {e_lv[n], k_lv[n], e_ai[n], k_ai[n]} = 4'b0101;
    end
    chk("mode", 24'(mode_o), 24'(e_md));
    chk("drive_en", 24'(pin_oe_o), 24'(e_oe));
    chk("drive_val", 24'(pin_o & e_oe), 24'(e_src & e_oe));
    chk("pullup", 24'(pullup_en_o), 24'(e_pu));
    chk("level", 24'(pin_level_o & k_lv), 24'(e_lv & k_lv));
    chk("alt_in", 24'(alt_in_o & k_ai), 24'(e_ai & k_ai));
    chk("analog", 24'(alt_in_analog_o), 24'(e_an));
  endtask : check_all

  // Mode sweep, random traffic, then reset between edges
  initial
  begin
    void'($urandom(81));
    #1 rst_b_i = 1'b0;  // Off the edge, so the clear must be asynchronous
    repeat (2) @(negedge clk_i);
    check_all();
    rst_b_i = 1'b1;
    for (int n = 0; n < 8; n++) wr(n, {n[2:0], 4'h0});
    repeat (3) @(negedge clk_i);
    check_all();
    repeat (200)
    begin
      wr($urandom % 8, 7'($urandom));
      alt_out_i = 32'($urandom);
      brd_en = 8'($urandom);
      brd_val = 8'($urandom);
      repeat (2) @(negedge clk_i);
      check_all();
    end
    brd_en = 8'h00;
    #3 rst_b_i = 1'b0;
    #2 cfg_m = '{default: '0};
    check_all();
    repeat (2) @(negedge clk_i);
    check_all();
    summarize();
  end

  // Cut a hang short
  initial
  begin
    #(2000 * 20);
    n_errors++;
    summarize();
  end
endmodule : test_io_port_bit_config
